// >>> src/cic_pkg.sv
// ----------------------------------------------------------------------------
// Purpose : Shared constants and types of the current input scan/calibrate block
// Assumes : One clock, synchronous active-high reset
// Notes   : Reference figures are plain defaults, overridable at the top
// ----------------------------------------------------------------------------
package cic_pkg;

	// ------------------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------------------
	localparam int NUM_CH  = 8;
	localparam int CH_W    = 3;
	localparam int SMP_W   = 16;
	localparam int GRP_N   = 4;
	localparam int GRP_W   = 2;
	localparam int FRAC    = 16;
	localparam int SCALE_W = 18;
	localparam int BUF_DEPTH = 2;

	// ------------------------------------------------------------------------
	// Calibration constants and reset values
	// ------------------------------------------------------------------------
	localparam logic [SCALE_W-1:0] SCALE_ONE = 18'h10000;
	localparam logic [SCALE_W-1:0] OFFS_RST  = 18'h00000;
	localparam logic [SMP_W-1:0]   SMP_MAX   = 16'hFFFF;
	localparam logic [SMP_W-1:0]   REF_NOM_DEF = 16'hC000;
	localparam logic [SMP_W-1:0]   REF_LO_DEF  = 16'hB800;
	localparam logic [SMP_W-1:0]   REF_HI_DEF  = 16'hC800;

	// ------------------------------------------------------------------------
	// Timing: reference sweep once per minute at 250 MHz
	// ------------------------------------------------------------------------
	localparam longint CAL_PERIOD_S   = 60;
	localparam longint CLK_HZ         = 250_000_000;
	localparam longint CAL_CYCLES_DEF = CAL_PERIOD_S * CLK_HZ;
	localparam int     CAL_CNT_W      = 36;

	// ------------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [CH_W-1:0]  ch;
		logic             fault;
		logic [SMP_W-1:0] value;
	} cic_word_t;

	typedef struct packed {
		logic             we;
		logic [CH_W-1:0]  ch;
		logic [GRP_W-1:0] group;
	} cic_cfg_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_CONV = 5'b00010,
		ST_REF  = 5'b00100,
		ST_OFFS = 5'b01000,
		ST_PUSH = 5'b10000
	} cic_state_t;

endpackage

// >>> src/cic_fifo.sv
// ----------------------------------------------------------------------------
// Purpose : Small valid/ready FIFO between the sequencer and the memory port
// Assumes : Same clock on both sides
// Notes   : Read data comes straight from the storage flops
// ----------------------------------------------------------------------------
`timescale 1ns/100ps
module cic_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ------------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------------
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
		$error("cic_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [WIDTH-1:0] nxt_mem [DEPTH];
	logic [PTR_W-1:0] wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
	logic [PTR_W:0]   cnt_ff, nxt_cnt;
	logic             push, pop;

	// Handshakes and head of queue
	assign in_ready  = (cnt_ff != (PTR_W+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem_ff[rptr_ff];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Next pointers, count and storage
	always_comb begin
		nxt_mem  = mem_ff;
		nxt_wptr = wptr_ff;
		nxt_rptr = rptr_ff;
		nxt_cnt  = cnt_ff;
		if (push) begin
			nxt_mem[wptr_ff] = in_data;
			nxt_wptr         = wptr_ff + 1'b1;
		end
		if (pop) begin
			nxt_rptr = rptr_ff + 1'b1;
		end
		if (push && !pop) begin
			nxt_cnt = cnt_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
	end

	// Register stage
	always_ff @(posedge clk) begin
		if (rst) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			cnt_ff  <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= '0;
			end
		end else begin
			wptr_ff <= nxt_wptr;
			rptr_ff <= nxt_rptr;
			cnt_ff  <= nxt_cnt;
			mem_ff  <= nxt_mem;
		end
	end

endmodule

// >>> src/cic_scan.sv
// ----------------------------------------------------------------------------
// Purpose : Channel scan, reference calibration and fault indication sequencer
// Assumes : Converter, config and key ports run on MCLK; BOARD_FAULT is a pin
// Notes   : Results leave through a two-entry FIFO toward the dual-port RAM
// ----------------------------------------------------------------------------
`timescale 1ns/100ps
module cic_scan
	import cic_pkg::*;
#(
	parameter longint          CAL_CYCLES = CAL_CYCLES_DEF,
	parameter logic [SMP_W-1:0] REF_NOM    = REF_NOM_DEF,
	parameter logic [SMP_W-1:0] REF_LO     = REF_LO_DEF,
	parameter logic [SMP_W-1:0] REF_HI     = REF_HI_DEF
) (
	// Clock and reset
	input  wire logic             MCLK,
	input  wire logic             SRST,
	// Host configuration and status
	input  wire cic_cfg_t         CFG,
	input  wire logic             INIT_DONE,
	input  wire logic             KEY_VALID,
	input  wire logic [GRP_N-1:0] KEY_GROUPS,
	// On-board status
	input  wire logic             SELFTEST_PASS,
	input  wire logic             BOARD_FAULT,
	// Multiplexers and converter
	output logic [CH_W-1:0]       MUX_CH,
	output logic                  MUX_REF,
	output logic                  ADC_START,
	input  wire logic             ADC_DONE,
	input  wire logic [SMP_W-1:0] ADC_DATA,
	// Dual-port memory write side
	output logic                  DPR_VALID,
	input  wire logic             DPR_READY,
	output cic_word_t             DPR_WORD,
	// Indicators
	output logic [NUM_CH-1:0]     CH_FAULT,
	output logic                  FAULT_LED
);

	// ------------------------------------------------------------------------
	// Derived constants and checks
	// ------------------------------------------------------------------------
	localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_CYCLES - 1);
	localparam logic [SCALE_W-1:0]   GAIN_K   = SCALE_W'(int'(SCALE_ONE) / int'(REF_NOM));
	localparam logic [CH_W-1:0]      CH_LAST  = CH_W'(NUM_CH - 1);

	if (CAL_CYCLES < 1 || CAL_CYCLES >= (64'd1 << CAL_CNT_W)) begin : g_bad_cal
		$error("cic_scan: CAL_CYCLES out of range");
	end
	if (REF_LO > REF_NOM || REF_NOM > REF_HI || REF_NOM == '0) begin : g_bad_ref
		$error("cic_scan: reference limits must bracket REF_NOM");
	end

	// ------------------------------------------------------------------------
	// Arithmetic helpers
	// ------------------------------------------------------------------------
	// Raw sample times unsigned fixed-point scale, fraction dropped
	function automatic logic [SCALE_W-1:0] apply_scale(input logic [SMP_W-1:0] raw,
		input logic [SCALE_W-1:0] scl);
		logic [SMP_W+SCALE_W-1:0] prod;
		prod = (SMP_W+SCALE_W)'(raw) * (SMP_W+SCALE_W)'(scl);
		return prod[FRAC+SCALE_W-1:FRAC];
	endfunction

	// Clamp a signed sum into the unsigned sample range
	function automatic logic [SMP_W-1:0] clamp(input logic signed [SCALE_W+1:0] v);
		if (v < 0) begin
			return '0;
		end else if (v > $signed({4'h0, SMP_MAX})) begin
			return SMP_MAX;
		end
		return v[SMP_W-1:0];
	endfunction

	// Lowest pending channel
	function automatic logic [CH_W-1:0] first_set(input logic [NUM_CH-1:0] m);
		logic [CH_W-1:0] r;
		r = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (m[i]) begin
				r = CH_W'(i);
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------------------
	// Pin synchroniser for the board fault input
	// ------------------------------------------------------------------------
	logic bf_meta_ff, bf_sync_ff;

	// Two flops before any use
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			bf_meta_ff <= 1'b0;
			bf_sync_ff <= 1'b0;
		end else begin
			bf_meta_ff <= BOARD_FAULT;
			bf_sync_ff <= bf_meta_ff;
		end
	end

	// ------------------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------------------
	cic_state_t             state_ff, nxt_state;
	logic [GRP_W-1:0]       grp_ff [NUM_CH], nxt_grp [NUM_CH];
	logic [SCALE_W-1:0]     scale_ff [NUM_CH], nxt_scale [NUM_CH];
	logic [SCALE_W-1:0]     offs_ff [NUM_CH], nxt_offs [NUM_CH];
	logic [SMP_W-1:0]       last_ff [NUM_CH], nxt_last [NUM_CH];
	logic [NUM_CH-1:0]      fault_ff, nxt_fault;
	logic [NUM_CH-1:0]      pend_ff, nxt_pend;
	logic [CAL_CNT_W-1:0]   cnt_ff, nxt_cnt;
	logic                   due_ff, nxt_due;
	logic [CH_W-1:0]        cal_ch_ff, nxt_cal_ch;
	logic [CH_W-1:0]        mux_ch_ff, nxt_mux_ch;
	logic                   mux_ref_ff, nxt_mux_ref;
	logic                   start_ff, nxt_start;
	logic [SMP_W-1:0]       ref_ff, nxt_ref;
	cic_word_t              word_ff, nxt_word;
	logic                   led_ff, nxt_led;
	logic                   buf_ready;
	logic [NUM_CH-1:0]      key_hits;
	logic                   init_ok;
	logic signed [SCALE_W+1:0] sum;
	logic signed [SCALE_W+1:0] diff;

	assign init_ok = SELFTEST_PASS & INIT_DONE;

	// Channels whose group the key names
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			key_hits[i] = KEY_VALID & init_ok & KEY_GROUPS[grp_ff[i]];
		end
	end

	// Correction of current sample and reference deviation
	always_comb begin
		sum  = $signed({2'b00, apply_scale(ADC_DATA, scale_ff[mux_ch_ff])})
			+ $signed({{2{offs_ff[mux_ch_ff][SCALE_W-1]}}, offs_ff[mux_ch_ff]});
		diff = $signed({4'h0, REF_NOM}) - $signed({4'h0, ref_ff});
	end

	// Next-state logic
	always_comb begin
		nxt_state   = state_ff;
		nxt_grp     = grp_ff;
		nxt_scale   = scale_ff;
		nxt_offs    = offs_ff;
		nxt_last    = last_ff;
		nxt_fault   = fault_ff;
		nxt_cal_ch  = cal_ch_ff;
		nxt_mux_ch  = mux_ch_ff;
		nxt_mux_ref = mux_ref_ff;
		nxt_start   = 1'b0;
		nxt_ref     = ref_ff;
		nxt_word    = word_ff;
		nxt_due     = due_ff;
		nxt_cnt     = cnt_ff + 1'b1;
		nxt_pend    = pend_ff | key_hits;
		if (CFG.we) begin
			nxt_grp[CFG.ch] = CFG.group;
		end
		unique case (state_ff)
			ST_IDLE: begin
				if (pend_ff != '0) begin
					nxt_mux_ch  = first_set(pend_ff);
					nxt_mux_ref = 1'b0;
					nxt_pend[first_set(pend_ff)] = key_hits[first_set(pend_ff)];
					nxt_start   = 1'b1;
					nxt_state   = ST_CONV;
				end else if (due_ff) begin
					nxt_mux_ch  = cal_ch_ff;
					nxt_mux_ref = 1'b1;
					nxt_start   = 1'b1;
					nxt_state   = ST_REF;
				end
			end
			ST_CONV: begin
				if (ADC_DONE) begin
					nxt_last[mux_ch_ff] = clamp(sum);
					nxt_word  = '{ch: mux_ch_ff, fault: fault_ff[mux_ch_ff], value: clamp(sum)};
					nxt_state = ST_PUSH;
				end
			end
			ST_REF: begin
				if (ADC_DONE) begin
					nxt_ref    = ADC_DATA;
					nxt_cal_ch = cal_ch_ff + 1'b1;
					if (cal_ch_ff == CH_LAST) begin
						nxt_due = 1'b0;
					end
					if (ADC_DATA < REF_LO || ADC_DATA > REF_HI) begin
						nxt_fault[mux_ch_ff] = 1'b1;
						nxt_word  = '{ch: mux_ch_ff, fault: 1'b1, value: last_ff[mux_ch_ff]};
						nxt_state = ST_PUSH;
					end else begin
						nxt_fault[mux_ch_ff] = 1'b0;
						nxt_state = ST_OFFS;
					end
				end
			end
			ST_OFFS: begin
				nxt_scale[mux_ch_ff] = SCALE_W'(SCALE_ONE + SCALE_W'(diff) * GAIN_K);
				nxt_offs[mux_ch_ff]  = SCALE_W'($signed({4'h0, REF_NOM})
					- $signed({2'b00, apply_scale(ref_ff, SCALE_W'(SCALE_ONE + SCALE_W'(diff) * GAIN_K))}));
				nxt_word  = '{ch: mux_ch_ff, fault: 1'b0, value: last_ff[mux_ch_ff]};
				nxt_state = ST_PUSH;
			end
			ST_PUSH: begin
				if (buf_ready) begin
					nxt_state = ST_IDLE;
				end
			end
		endcase
		if (cnt_ff == CAL_LAST) begin
			nxt_cnt    = '0;
			nxt_due    = 1'b1;
		end
		if (!due_ff && nxt_due) begin
			nxt_cal_ch = '0;
		end
		nxt_led = ~init_ok | (|fault_ff) | bf_sync_ff;
	end

	// Register stage
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			state_ff   <= ST_IDLE;
			fault_ff   <= '0;
			pend_ff    <= '0;
			cnt_ff     <= '0;
			due_ff     <= 1'b1;
			cal_ch_ff  <= '0;
			mux_ch_ff  <= '0;
			mux_ref_ff <= 1'b0;
			start_ff   <= 1'b0;
			ref_ff     <= '0;
			word_ff    <= '0;
			led_ff     <= 1'b1;
			for (int i = 0; i < NUM_CH; i++) begin
				grp_ff[i]   <= '0;
				scale_ff[i] <= SCALE_ONE;
				offs_ff[i]  <= OFFS_RST;
				last_ff[i]  <= '0;
			end
		end else begin
			state_ff   <= nxt_state;
			grp_ff     <= nxt_grp;
			scale_ff   <= nxt_scale;
			offs_ff    <= nxt_offs;
			last_ff    <= nxt_last;
			fault_ff   <= nxt_fault;
			pend_ff    <= nxt_pend;
			cnt_ff     <= nxt_cnt;
			due_ff     <= nxt_due;
			cal_ch_ff  <= nxt_cal_ch;
			mux_ch_ff  <= nxt_mux_ch;
			mux_ref_ff <= nxt_mux_ref;
			start_ff   <= nxt_start;
			ref_ff     <= nxt_ref;
			word_ff    <= nxt_word;
			led_ff     <= nxt_led;
		end
	end

	// ------------------------------------------------------------------------
	// Output buffer toward the dual-port memory
	// ------------------------------------------------------------------------
	cic_fifo #(
		.WIDTH ($bits(cic_word_t)),
		.DEPTH (BUF_DEPTH)
	) u_fifo (
		.clk       (MCLK),
		.rst       (SRST),
		.in_valid  (state_ff == ST_PUSH),
		.in_ready  (buf_ready),
		.in_data   (word_ff),
		.out_valid (DPR_VALID),
		.out_ready (DPR_READY),
		.out_data  (DPR_WORD)
	);

	// Registered outputs
	assign MUX_CH    = mux_ch_ff;
	assign MUX_REF   = mux_ref_ff;
	assign ADC_START = start_ff;
	assign CH_FAULT  = fault_ff;
	assign FAULT_LED = led_ff;

endmodule

// >>> sim/cic_scan_monitor.sv
// Purpose: port assertions of the scan block
// Assumes: one clock, SRST synchronous active high
// Notes  : bound into every cic_scan
`timescale 1ns/100ps
module cic_scan_monitor
	import cic_pkg::*;
#(
	parameter logic [SMP_W-1:0] REF_LO = REF_LO_DEF,
	parameter logic [SMP_W-1:0] REF_HI = REF_HI_DEF
) (
	// Clock and reset
	input wire logic              MCLK,
	input wire logic              SRST,
	// Status
	input wire logic              SELFTEST_PASS,
	input wire logic              INIT_DONE,
	input wire logic              BOARD_FAULT,
	// Converter
	input wire logic [CH_W-1:0]   MUX_CH,
	input wire logic              MUX_REF,
	input wire logic              ADC_START,
	input wire logic              ADC_DONE,
	input wire logic [SMP_W-1:0]  ADC_DATA,
	// Memory side
	input wire logic              DPR_VALID,
	input wire logic              DPR_READY,
	input wire cic_word_t         DPR_WORD,
	// Indicators
	input wire logic [NUM_CH-1:0] CH_FAULT,
	input wire logic              FAULT_LED
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SRST);
	logic bad_ref;
	// Reference outside limits
	assign bad_ref = (ADC_DATA < REF_LO) || (ADC_DATA > REF_HI);
	property p_led_init; !(SELFTEST_PASS && INIT_DONE) |=> FAULT_LED; endproperty
	a_led_init: assert property (p_led_init) else $error("led off before init");
	property p_led_chf; (CH_FAULT != 8'h00) |=> FAULT_LED; endproperty
	a_led_chf: assert property (p_led_chf) else $error("led off with channel fault");
	property p_led_board; BOARD_FAULT [*3] |=> FAULT_LED; endproperty
	a_led_board: assert property (p_led_board) else $error("led off with board fault");
	property p_led_off;
		(SELFTEST_PASS && INIT_DONE && CH_FAULT == 8'h00 && !BOARD_FAULT) [*3] |=> !FAULT_LED;
	endproperty
	a_led_off: assert property (p_led_off) else $error("led lit without cause");
	property p_mux_hold;
		ADC_START |=> ($stable(MUX_CH) && $stable(MUX_REF) && !ADC_START) [*2];
	endproperty
	a_mux_hold: assert property (p_mux_hold) else $error("selection moved in conversion");
	property p_dpr_hold; DPR_VALID && !DPR_READY |=> DPR_VALID && $stable(DPR_WORD); endproperty
	a_dpr_hold: assert property (p_dpr_hold) else $error("memory word dropped");
	property p_ref_fault; ADC_DONE && MUX_REF && bad_ref |-> ##[1:3] CH_FAULT[MUX_CH]; endproperty
	a_ref_fault: assert property (p_ref_fault) else $error("bad reference not flagged");
	property p_ref_clear; ADC_DONE && MUX_REF && !bad_ref |-> ##[1:3] !CH_FAULT[MUX_CH]; endproperty
	a_ref_clear: assert property (p_ref_clear) else $error("good reference kept fault");
	property p_field_push;
		ADC_DONE && !MUX_REF && !DPR_VALID |-> ##2 DPR_VALID && DPR_WORD.ch == $past(MUX_CH, 2);
	endproperty
	a_field_push: assert property (p_field_push) else $error("field word not written");
endmodule
bind cic_scan cic_scan_monitor #(.REF_LO(REF_LO), .REF_HI(REF_HI)) u_mon (.MCLK(MCLK), .SRST(SRST),
	.SELFTEST_PASS(SELFTEST_PASS), .INIT_DONE(INIT_DONE), .BOARD_FAULT(BOARD_FAULT), .MUX_CH(MUX_CH),
	.MUX_REF(MUX_REF), .ADC_START(ADC_START), .ADC_DONE(ADC_DONE), .ADC_DATA(ADC_DATA), .DPR_VALID(DPR_VALID),
	.DPR_READY(DPR_READY), .DPR_WORD(DPR_WORD), .CH_FAULT(CH_FAULT), .FAULT_LED(FAULT_LED));

// >>> sim/cic_adc_model.sv
// Purpose: converter behind the multiplexers
// Assumes: one conversion at a time
// Notes  : data is scrambled outside the done pulse
`timescale 1ns/100ps
module cic_adc_model
	import cic_pkg::*;
(
	// Clock
	input wire logic              clk,
	// Selection
	input wire logic [CH_W-1:0]   mux_ch,
	input wire logic              mux_ref,
	input wire logic              start,
	// Bench controls
	input wire logic [NUM_CH-1:0] ref_bad,
	input wire logic              slow,
	// Answer
	output logic                  done,
	output logic [SMP_W-1:0]      data
);
	int wait_n;
	// Answer each start, promptly or slowly
	initial begin
		done = 1'b0;
		data = 16'h5A5A;
		forever begin
			@(posedge clk);
			if (start) begin
				wait_n = slow ? 2 + $urandom % 7 : 0;
				repeat (wait_n) @(posedge clk);
				@(negedge clk);
				if (!mux_ref) data = 16'($urandom);
				else if (ref_bad[mux_ch]) data = mux_ch[0] ? REF_HI_DEF + 16'h0001 : REF_LO_DEF - 16'h0001;
				else data = REF_NOM_DEF;
				done = 1'b1;
				@(negedge clk);
				done = 1'b0;
				data = ~data;
			end
		end
	end
endmodule

// >>> sim/tb_top.sv
// Purpose: self-checking bench of the scan block
// Assumes: nominal references give unit scale, zero offset
// Notes  : reference period shortened to 200 cycles
`timescale 1ns/100ps
module tb_top;
	import cic_pkg::*;
	logic MCLK = 1'b0, SRST = 1'b1, INIT_DONE = 1'b0, KEY_VALID = 1'b0;
	logic SELFTEST_PASS = 1'b0, BOARD_FAULT = 1'b0, DPR_READY = 1'b0;
	cic_cfg_t CFG = '0;
	logic [GRP_N-1:0] KEY_GROUPS = '0;
	logic [CH_W-1:0] MUX_CH;
	logic MUX_REF, ADC_START, ADC_DONE, DPR_VALID, FAULT_LED;
	logic [SMP_W-1:0] ADC_DATA;
	cic_word_t DPR_WORD, w;
	logic [NUM_CH-1:0] CH_FAULT, pend = '0, hit_d = '0, flt = '0, ref_bad = '0;
	logic stall = 1'b0, slow = 1'b0, cur_ref;
	int grp[NUM_CH], lastv[NUM_CH], cur_ch, v, i, bad_count, checks, cycles;
	cic_word_t expq[$];
	always #2 MCLK = ~MCLK;
	cic_scan #(.CAL_CYCLES(200)) dut (.MCLK(MCLK), .SRST(SRST), .CFG(CFG), .INIT_DONE(INIT_DONE),
		.KEY_VALID(KEY_VALID), .KEY_GROUPS(KEY_GROUPS), .SELFTEST_PASS(SELFTEST_PASS),
		.BOARD_FAULT(BOARD_FAULT), .MUX_CH(MUX_CH), .MUX_REF(MUX_REF), .ADC_START(ADC_START),
		.ADC_DONE(ADC_DONE), .ADC_DATA(ADC_DATA), .DPR_VALID(DPR_VALID), .DPR_READY(DPR_READY),
		.DPR_WORD(DPR_WORD), .CH_FAULT(CH_FAULT), .FAULT_LED(FAULT_LED));
	cic_adc_model u_adc (.clk(MCLK), .mux_ch(MUX_CH), .mux_ref(MUX_REF), .start(ADC_START),
		.ref_bad(ref_bad), .slow(slow), .done(ADC_DONE), .data(ADC_DATA));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (exp !== got) begin
			bad_count++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic end_of_test();
		if (bad_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic send_key(input logic [GRP_N-1:0] g);
		KEY_GROUPS = g;
		KEY_VALID = 1'b1;
		@(negedge MCLK);
		KEY_VALID = 1'b0;
		@(negedge MCLK);
	endtask
	task automatic cfg_all();
		for (int c = 0; c < NUM_CH; c++) begin
			CFG = '{we: 1'b1, ch: 3'(c), group: 2'($urandom % 4)};
			@(negedge MCLK);
			CFG.we = 1'b0;
			@(negedge MCLK);
		end
	endtask
	// Memory side accepts at random or stalls
	always @(negedge MCLK) DPR_READY <= !stall && ($urandom % 4 != 0);
	// Reference model of scheduling, correction and faults
	always @(posedge MCLK) begin
		cycles++;
		if (cycles > 20000) begin
			bad_count++;
			end_of_test();
		end else if (SRST) begin
			pend = '0;
			hit_d = '0;
			flt = '0;
			foreach (lastv[c]) lastv[c] = 0;
			foreach (grp[c]) grp[c] = 0;
			expq.delete();
		end else begin
			if (ADC_START && !MUX_REF) begin
				chk("field_pending", 1, pend[MUX_CH]);
				chk("field_lowest", 0, pend & ((8'h01 << MUX_CH) - 8'h01));
				pend[MUX_CH] = 1'b0;
			end
			if (ADC_START && MUX_REF) chk("ref_idle", 0, pend);
			if (ADC_START) begin
				cur_ref = MUX_REF;
				cur_ch = MUX_CH;
			end
			// Keys join the pending mask one edge after they are taken
			pend = pend | hit_d;
			hit_d = '0;
			if (KEY_VALID && SELFTEST_PASS && INIT_DONE) begin
				for (int c = 0; c < NUM_CH; c++) if (KEY_GROUPS[grp[c]]) hit_d[c] = 1'b1;
			end
			// Group writes count from the next edge on
			if (CFG.we) grp[CFG.ch] = CFG.group;
			if (ADC_DONE) begin
				w.ch = 3'(cur_ch);
				if (cur_ref) begin
					flt[cur_ch] = ADC_DATA < REF_LO_DEF || ADC_DATA > REF_HI_DEF;
					w.value = 16'(lastv[cur_ch]);
				end else begin
					// Unit scale, zero offset, clamped
					v = (int'(ADC_DATA) * 65536) >>> 16;
					w.value = v > 65535 ? 16'hFFFF : 16'(v);
					lastv[cur_ch] = int'(w.value);
				end
				w.fault = flt[cur_ch];
				expq.push_back(w);
			end
			if (DPR_VALID && DPR_READY) begin
				if (expq.size() == 0) chk("extra_word", 0, 1);
				else begin
					w = expq.pop_front();
					chk("word_ch", w.ch, DPR_WORD.ch);
					chk("word_fault", w.fault, DPR_WORD.fault);
					chk("word_value", w.value, DPR_WORD.value);
				end
			end
		end
	end
	// Main sequence
	initial begin
		void'($urandom(32'h5D034468));
		repeat (4) @(negedge MCLK);
		SRST = 1'b0;
		chk("led_reset", 1, FAULT_LED);
		send_key(4'hF);
		cfg_all();
		repeat (300) @(negedge MCLK);
		chk("led_no_init", 1, FAULT_LED);
		SELFTEST_PASS = 1'b1;
		repeat (20) @(negedge MCLK);
		chk("led_selftest_only", 1, FAULT_LED);
		INIT_DONE = 1'b1;
		repeat (5) @(negedge MCLK);
		chk("led_init_done", 0, FAULT_LED);
		for (i = 0; i < 4; i++) send_key(4'h1 << i);
		for (i = 0; i < 40; i++) begin
			slow = i > 20;
			send_key(4'($urandom));
			repeat ($urandom % 30) @(negedge MCLK);
		end
		stall = 1'b1;
		send_key(4'hF);
		repeat (200) @(negedge MCLK);
		chk("stall_backlog", 3, expq.size());
		stall = 1'b0;
		// Prompt converter from here, so a conversion never outlives the second reset
		slow = 1'b0;
		ref_bad = 8'h24;
		repeat (300) @(negedge MCLK);
		send_key(4'hF);
		repeat (400) @(negedge MCLK);
		chk("faults_set", 8'h24, CH_FAULT);
		chk("led_faults", 1, FAULT_LED);
		ref_bad = '0;
		repeat (700) @(negedge MCLK);
		chk("faults_clear", 0, CH_FAULT);
		BOARD_FAULT = 1'b1;
		repeat (6) @(negedge MCLK);
		chk("led_board", 1, FAULT_LED);
		BOARD_FAULT = 1'b0;
		repeat (6) @(negedge MCLK);
		chk("led_board_gone", 0, FAULT_LED);
		SRST = 1'b1;
		repeat (4) @(negedge MCLK);
		SRST = 1'b0;
		chk("led_second_reset", 1, FAULT_LED);
		cfg_all();
		send_key(4'($urandom));
		for (i = 0; i < 2000 && (expq.size() != 0 || pend != 0 || hit_d != 0); i++) @(negedge MCLK);
		chk("drained", 0, expq.size());
		end_of_test();
	end
endmodule
